// >>> design/tct_pkg.sv
// constants and types for the thermal clock throttle block
package tct_pkg;
    // register offsets of the software port
    localparam logic [3:0] ADDR_SW_THROTTLE = 4'h0;
    localparam logic [3:0] ADDR_CONFIG = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    // software throttle field positions
    localparam int SW_EN_BIT = 4;
    localparam int SW_DUTY_LO = 1;
    localparam int SW_DUTY_HI = 3;
    // config field positions
    localparam int CFG_PROT_EN_BIT = 0;
    localparam int CFG_IRQ_RISE_BIT = 1;
    localparam int CFG_IRQ_FALL_BIT = 2;
    // reset values
    localparam logic [4:0] SW_THROTTLE_RESET = 5'h00;
    localparam logic [2:0] CONFIG_RESET = 3'h1;
    // modulation period in eighths; factory duty in eighths on
    localparam int PERIOD_STEPS = 8;
    localparam logic [2:0] FACTORY_DUTY_ON = 3'h4;
    // longest clock-off interval and derived cycle count
    localparam int CLK_MHZ = 40;
    localparam int MAX_OFF_NS = 3000;
    localparam int MAX_OFF_CYCLES = (MAX_OFF_NS * CLK_MHZ) / 1000;
    // default step length so that 7 off-steps stay within the off limit
    localparam int STEP_CYCLES_DEFAULT = MAX_OFF_CYCLES / PERIOD_STEPS;
    localparam int HYST_CYCLES_DEFAULT = 4000;

    typedef enum logic [1:0] {
        TCT_IDLE = 2'b00,
        TCT_AUTO = 2'b01,
        TCT_HYST = 2'b10
    } tct_mode_t;
endpackage : tct_pkg

// >>> design/tct_modulator.sv
// clock gate pattern generator for a given on-fraction
`timescale 1ns/1ps
module tct_modulator #(
    parameter int STEP_CYCLES = 15
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_active,
    input wire logic [2:0] i_duty_on,
    output logic o_clk_on
);
    typedef struct packed {
        logic [15:0] cyc;
        logic [2:0] step;
        logic on;
    } tct_mod_state_t;

    tct_mod_state_t st;
    tct_mod_state_t next_st;

    always_comb begin
        next_st = st;
        if (!i_active) begin
            next_st.cyc = 16'h0000;
            next_st.step = 3'h0;
            next_st.on = 1'b1;
        end else begin
            if (st.cyc >= 16'(STEP_CYCLES - 1)) begin
                next_st.cyc = 16'h0000;
                next_st.step = st.step + 3'h1;
            end else begin
                next_st.cyc = st.cyc + 16'h0001;
            end
            // zero code gives one eighth on, minimum fraction
            next_st.on = (next_st.step <= ((i_duty_on == 3'h0) ? 3'h0 : i_duty_on - 3'h1));
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '{cyc: 16'h0000, step: 3'h0, on: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign o_clk_on = st.on;
endmodule : tct_modulator

// >>> design/tct_throttle.sv
// thermal clock throttle top: automatic and software throttling
`timescale 1ns/1ps
module tct_throttle #(
    parameter int STEP_CYCLES = tct_pkg::STEP_CYCLES_DEFAULT,
    parameter int HYST_CYCLES = tct_pkg::HYST_CYCLES_DEFAULT
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    // software port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // on-die sensor comparators, threshold fixed in silicon
    input wire logic i_die_at_max,
    input wire logic i_die_catastrophic,
    // hot pin, active low, open-drain
    input wire logic i_die_hot_indication_n,
    output logic o_die_hot_indication_n,
    output logic o_die_hot_indication_oe,
    // shutdown pin, active low
    output logic o_overheat_shutdown_n,
    // core side
    output logic o_core_clk_en,
    output logic o_throttle_active,
    input wire logic i_irq_req,
    output logic o_irq_service,
    output logic o_hot_irq
);
    typedef struct packed {
        logic [4:0] sw_ctl;
        logic [2:0] cfg;
        tct_pkg::tct_mode_t mode;
        logic [15:0] hyst;
        logic pin_hot_d;
        logic irq_pend;
        logic irq_svc;
        logic hot_irq;
        logic trip;
        logic [7:0] rdata;
    } tct_state_t;

    tct_state_t st;
    tct_state_t next_st;
    logic pin_hot;
    logic hot_any;
    logic auto_on;
    logic sw_on;
    logic mod_active;
    logic [2:0] duty;
    logic clk_on;
    logic clk_run;

    // ------------------------------------------------------------
    // throttle decision
    // ------------------------------------------------------------
    // pin level seen includes our own drive and any external pull-low
    assign pin_hot = !i_die_hot_indication_n;
    assign hot_any = i_die_at_max || pin_hot;
    assign auto_on = (st.mode != tct_pkg::TCT_IDLE);
    assign sw_on = st.sw_ctl[tct_pkg::SW_EN_BIT];
    assign mod_active = (auto_on || sw_on) && !st.trip;
    assign duty = auto_on ? tct_pkg::FACTORY_DUTY_ON
                          : st.sw_ctl[tct_pkg::SW_DUTY_HI:tct_pkg::SW_DUTY_LO];

    tct_modulator #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_mod (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_active(mod_active),
        .i_duty_on(duty),
        .o_clk_on(clk_on)
    );

    // core clocks really run only while no trip holds them
    assign clk_run = clk_on && !st.trip;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.rdata = 8'h00;
        next_st.irq_svc = 1'b0;
        next_st.pin_hot_d = pin_hot;
        if (i_wr && i_addr == tct_pkg::ADDR_SW_THROTTLE) begin
            next_st.sw_ctl = i_wdata[4:0];
        end
        if (i_wr && i_addr == tct_pkg::ADDR_CONFIG) begin
            next_st.cfg = i_wdata[2:0];
        end
        case (st.mode)
            tct_pkg::TCT_IDLE: begin
                if (hot_any && st.cfg[tct_pkg::CFG_PROT_EN_BIT]) begin
                    next_st.mode = tct_pkg::TCT_AUTO;
                end
            end
            tct_pkg::TCT_AUTO: begin
                if (!hot_any) begin
                    next_st.mode = tct_pkg::TCT_HYST;
                    next_st.hyst = 16'h0000;
                end
            end
            tct_pkg::TCT_HYST: begin
                if (hot_any) begin
                    next_st.mode = tct_pkg::TCT_AUTO;
                end else if (st.hyst >= 16'(HYST_CYCLES - 1)) begin
                    next_st.mode = tct_pkg::TCT_IDLE;
                end else begin
                    next_st.hyst = st.hyst + 16'h0001;
                end
            end
            default: begin
                next_st.mode = tct_pkg::TCT_IDLE;
            end
        endcase
        if (!st.cfg[tct_pkg::CFG_PROT_EN_BIT]) begin
            next_st.mode = tct_pkg::TCT_IDLE;
        end
        // interrupt requests wait for a clocks-on interval
        if (clk_run && (st.irq_pend || i_irq_req)) begin
            next_st.irq_svc = 1'b1;
            next_st.irq_pend = 1'b0;
        end else if (i_irq_req) begin
            next_st.irq_pend = 1'b1;
        end
        // status read clears the edge flag; a new edge wins
        if (i_rd && i_addr == tct_pkg::ADDR_STATUS) begin
            next_st.hot_irq = 1'b0;
        end
        if ((pin_hot && !st.pin_hot_d && st.cfg[tct_pkg::CFG_IRQ_RISE_BIT])
            || (!pin_hot && st.pin_hot_d && st.cfg[tct_pkg::CFG_IRQ_FALL_BIT])) begin
            next_st.hot_irq = 1'b1;
        end
        // trip holds until reset, regardless of protection enable
        if (i_die_catastrophic) begin
            next_st.trip = 1'b1;
        end
        if (i_rd) begin
            case (i_addr)
                tct_pkg::ADDR_SW_THROTTLE: next_st.rdata = {3'h0, st.sw_ctl};
                tct_pkg::ADDR_CONFIG: next_st.rdata = {5'h00, st.cfg};
                tct_pkg::ADDR_STATUS: next_st.rdata = {3'h0, st.trip, st.hot_irq, pin_hot,
                                                        mod_active, auto_on};
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '{sw_ctl: tct_pkg::SW_THROTTLE_RESET, cfg: tct_pkg::CONFIG_RESET,
                    mode: tct_pkg::TCT_IDLE, hyst: 16'h0000, pin_hot_d: 1'b0,
                    irq_pend: 1'b0, irq_svc: 1'b0, hot_irq: 1'b0, trip: 1'b0,
                    rdata: 8'h00};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_die_hot_indication_n = 1'b0;
    assign o_die_hot_indication_oe = i_die_at_max;
    assign o_overheat_shutdown_n = !st.trip;
    assign o_core_clk_en = clk_run;
    assign o_throttle_active = mod_active;
    assign o_irq_service = st.irq_svc;
    assign o_hot_irq = st.hot_irq;
    assign o_rdata = st.rdata;
endmodule : tct_throttle

// >>> dv/tct_system_model.sv
// system side: external hot pin pull and supply removal
`timescale 1ns/1ps
module tct_system_model (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_pull,
    input wire logic i_die_hot_indication_oe,
    input wire logic i_overheat_shutdown_n,
    output logic o_pin_n,
    output logic o_supply_off
);
    // pull-up unless someone drives low
    assign o_pin_n = !(i_pull || i_die_hot_indication_oe);
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) o_supply_off <= 1'h0;
        else if (!i_overheat_shutdown_n) o_supply_off <= 1'h1;
    end
endmodule : tct_system_model

// >>> dv/tct_throttle_properties.sv
// port assertions for the throttle top
`timescale 1ns/1ps
module tct_throttle_properties #(
    parameter int STEP_CYCLES = 2,
    parameter int HYST_CYCLES = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_die_at_max,
    input wire logic i_die_catastrophic,
    input wire logic i_die_hot_indication_n,
    input wire logic o_die_hot_indication_n,
    input wire logic o_die_hot_indication_oe,
    input wire logic o_overheat_shutdown_n,
    input wire logic o_core_clk_en,
    input wire logic o_throttle_active,
    input wire logic i_irq_req,
    input wire logic o_irq_service
);
    // ----
    // shadow of config and cycle counters
    // ----
    logic prot;
    logic sw_on;
    int cool;
    int off;
    // longest off stretch plus two cycles to deliver the request
    localparam int SVC_WAIT = 7 * STEP_CYCLES + 2;
    wire hot = i_die_at_max || !i_die_hot_indication_n;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            prot <= 1'h1;
            sw_on <= 1'h0;
            cool <= 0;
            off <= 0;
        end else begin
            if (i_wr && i_addr == 4'h1) prot <= i_wdata[0];
            if (i_wr && i_addr == 4'h0) sw_on <= i_wdata[4];
            cool <= hot ? 0 : (cool < HYST_CYCLES + 9 ? cool + 1 : cool);
            off <= o_core_clk_en ? 0 : off + 1;
        end
    end
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);
    sequence s_hot;
        hot && prot && o_overheat_shutdown_n && !i_die_catastrophic;
    endsequence
    sequence s_fall;
        $fell(o_throttle_active) && prot && !sw_on && o_overheat_shutdown_n;
    endsequence
    auto_on_a: assert property (s_hot |-> ##[1:2] o_throttle_active)
        else $error("no throttle while hot");
    hyst_min_a: assert property (s_fall |-> cool >= HYST_CYCLES - 1)
        else $error("early release");
    hyst_max_a: assert property (cool == HYST_CYCLES + 4 && prot && !sw_on
        |-> !o_throttle_active) else $error("late release");
    hot_pin_a: assert property (o_die_hot_indication_oe == i_die_at_max
        && !o_die_hot_indication_n) else $error("hot pin drive");
    trip_set_a: assert property (i_die_catastrophic |=> !o_overheat_shutdown_n)
        else $error("no trip");
    trip_gate_a: assert property (!o_overheat_shutdown_n |-> !o_core_clk_en)
        else $error("clock after trip");
    irq_on_a: assert property (i_irq_req && o_core_clk_en |=> o_irq_service)
        else $error("irq not served");
    off_max_a: assert property (o_overheat_shutdown_n |-> off <= 7 * STEP_CYCLES)
        else $error("off too long");
    irq_gate_a: assert property (o_irq_service |-> $past(o_core_clk_en))
        else $error("irq served while clocks off");
    irq_held_a: assert property (i_irq_req && !o_core_clk_en && o_overheat_shutdown_n
        |-> ##[1:SVC_WAIT] (o_irq_service || !o_overheat_shutdown_n))
        else $error("latched irq lost");
    trip_hold_a: assert property (!o_overheat_shutdown_n |=> !o_overheat_shutdown_n)
        else $error("trip released");
endmodule : tct_throttle_properties

// >>> dv/tct_throttle_test.sv
// bench for the thermal clock throttle
`timescale 1ns/1ps
module tct_throttle_test;
    localparam int STEP = 2;
    localparam int HYST = 8;
    logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, rd_q = 1'h0, irq = 1'h0;
    logic at_max = 1'h0, cat = 1'h0, pull = 1'h0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic pin_n, oe, drv_n, trip_n, clk_en, thr, svc, hot_irq, sup_off;
    logic [7:0] exp_q[$];
    int num_errors = 0, samples_checked = 0, cycles = 0, seed = 32'h26c855aa, n;
    tct_throttle #(.STEP_CYCLES(STEP), .HYST_CYCLES(HYST)) u_tct_throttle (
        .i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_die_at_max(at_max), .i_die_catastrophic(cat),
        .i_die_hot_indication_n(pin_n), .o_die_hot_indication_n(drv_n),
        .o_die_hot_indication_oe(oe), .o_overheat_shutdown_n(trip_n),
        .o_core_clk_en(clk_en), .o_throttle_active(thr), .i_irq_req(irq),
        .o_irq_service(svc), .o_hot_irq(hot_irq));
    tct_system_model u_tct_system_model (.i_core_clk(clk), .i_rst(rst), .i_pull(pull),
        .i_die_hot_indication_oe(oe), .i_overheat_shutdown_n(trip_n), .o_pin_n(pin_n),
        .o_supply_off(sup_off));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) rd_q <= rd;
    always @(posedge clk) irq <= 1'($random(seed));
    always @(negedge clk) if (rd_q) chk(rdata, exp_q.pop_front());
    always @(posedge clk) if (++cycles == 3000) begin
        num_errors++;
        conclude();
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // one write, or one read with its expected data
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        if (!w) exp_q.push_back(d);
        @(posedge clk);
    endtask : bus
    task automatic idle(input int c);
        wr <= 1'h0;
        rd <= 1'h0;
        repeat (c) @(posedge clk);
        #1;
    endtask : idle
    task automatic on_count(input int exp);
        n = 0;
        repeat (8 * STEP) @(negedge clk) n += clk_en;
        chk(8'(n), 8'(exp));
        @(posedge clk);
    endtask : on_count
    task automatic conclude();
        $display("checked %0d wrong %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        bus(0, 4'h0, 8'h00);
        bus(0, 4'h1, 8'h01);
        bus(0, 4'h2, 8'h00);
        bus(1, 4'h7, 8'hFF);
        bus(0, 4'h7, 8'h00);
        bus(1, 4'h1, 8'h03);
        for (int k = 0; k < 8; k++) begin
            bus(1, 4'h0, {3'h0, 1'h1, k[2:0], 1'h0});
            bus(0, 4'h2, 8'h02);
            bus(0, 4'h0, {3'h0, 1'h1, k[2:0], 1'h0});
            idle(2 * STEP);
            on_count((k == 0 ? 1 : k) * STEP);
        end
        $display("software duty done");
        at_max <= 1'h1;
        idle(3);
        chk({7'h0, hot_irq}, 8'h01);
        bus(0, 4'h2, 8'h0F);
        bus(1, 4'h0, {3'h0, 1'h1, 3'($random(seed)), 1'h0});
        idle(2 * STEP);
        on_count(4 * STEP);
        at_max <= 1'h0;
        bus(1, 4'h0, 8'h00);
        idle(HYST - 3);
        chk({7'h0, thr}, 8'h01);
        idle(8);
        chk({7'h0, thr}, 8'h00);
        $display("automatic throttle done");
        bus(1, 4'h1, 8'h05);
        pull <= 1'h1;
        idle(3);
        chk({6'h0, thr, hot_irq}, 8'h02);
        pull <= 1'h0;
        idle(3);
        chk({6'h0, thr, hot_irq}, 8'h03);
        bus(1, 4'h1, 8'h00);
        at_max <= 1'h1;
        idle(4);
        chk({6'h0, oe, thr}, 8'h02);
        cat <= 1'h1;
        idle(3);
        cat <= 1'h0;
        idle(3);
        chk({5'h0, trip_n, clk_en, sup_off}, 8'h01);
        bus(0, 4'h2, 8'h1C);
        idle(2);
        $display("pin and trip done");
        conclude();
    end
endmodule : tct_throttle_test
bind tct_throttle tct_throttle_properties #(.STEP_CYCLES(STEP_CYCLES),
    .HYST_CYCLES(HYST_CYCLES)) u_tct_throttle_properties (.*);
